// file: tb/hwm_front_end.sv
// Behavioural sensing front end: hands over one set of readings per toggle.
// Assumes the caller spaces sets apart; slack adds idle cycles.
`timescale 1ns/100ps
`default_nettype none
module hwm_front_end (
    // Clock
    input wire logic i_clk,
    // Readings to the block
    output var hwm_pkg::hwm_reading_type o_reading,
    output var logic o_sample_toggle
);
    import hwm_pkg::*;
    initial begin
        o_reading = '0;
        o_sample_toggle = 1'b0;
    end
    task automatic send(input hwm_reading_type r, input int slack);
        @(posedge i_clk);
        o_reading <= r;
        o_sample_toggle <= ~o_sample_toggle;
        repeat (6) @(posedge i_clk);
        // Hold time over, so stop showing the old set
        o_reading <= ~r;
        repeat (slack) @(posedge i_clk);
    endtask : send
endmodule : hwm_front_end
`default_nettype wire

// file: tb/hwm_limit_monitor.sv
// Port-level checker for the hardware-monitor limit block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module hwm_limit_monitor (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Block inputs
    input wire hwm_pkg::hwm_reading_type i_reading,
    input wire logic i_sample_toggle,
    input wire hwm_pkg::hwm_reg_req_type i_req,
    // Block outputs
    input wire logic [7:0] o_rdata,
    input wire logic o_power_mgmt_event_out_n,
    input wire logic o_buzzer_out,
    input wire logic o_irq
);
    import hwm_pkg::*;
    logic tog_r;
    logic [3:0] age_r;
    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the last toggle, saturating
    always_ff @(posedge i_clk) begin
        tog_r <= i_sample_toggle;
        if (i_rst || tog_r != i_sample_toggle) begin
            age_r <= 4'h0;
        end else if (age_r != 4'hF) begin
            age_r <= age_r + 4'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // No sample in flight and no write lately, so no output cause
    sequence s_quiet;
        age_r > 4'h7 && !$past(i_req.wr) && !$past(i_req.wr, 2);
    endsequence
    sequence s_read(logic [7:0] a);
        i_req.rd && i_req.addr == a;
    endsequence
    property p_rdata_idle;
        !$past(i_req.rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_rsvd_ff;
        i_req.rd && i_req.addr inside {[8'h29:8'h2F]} |=> o_rdata == 8'hFF;
    endproperty
    a_rsvd_ff: assert property (p_rsvd_ff) else $error("reserved reading wrong");
    property p_volt_live_bits;
        s_read(8'h12) |=> (o_rdata & 8'hFD) == 8'h00;
    endproperty
    a_volt_live_bits: assert property (p_volt_live_bits) else $error("12h spare bits");
    property p_temp_live_bits;
        s_read(8'h62) |=> (o_rdata & 8'h99) == 8'h00;
    endproperty
    a_temp_live_bits: assert property (p_temp_live_bits) else $error("62h spare bits");
    property p_reset_idle;
        $fell(i_rst) |-> o_power_mgmt_event_out_n && !o_buzzer_out && !o_irq && o_rdata == 8'h00;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle");
    property p_evt_steady;
        s_quiet |-> $stable(o_power_mgmt_event_out_n);
    endproperty
    a_evt_steady: assert property (p_evt_steady) else $error("event moved alone");
    property p_buzz_steady;
        s_quiet |-> $stable(o_buzzer_out);
    endproperty
    a_buzz_steady: assert property (p_buzz_steady) else $error("buzzer moved alone");
    property p_irq_steady;
        s_quiet |-> $stable(o_irq);
    endproperty
    a_irq_steady: assert property (p_irq_steady) else $error("irq moved alone");
endmodule : hwm_limit_monitor
bind hwm_limit_status hwm_limit_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
    .i_reading(i_reading), .i_sample_toggle(i_sample_toggle), .i_req(i_req),
    .o_rdata(o_rdata), .o_power_mgmt_event_out_n(o_power_mgmt_event_out_n),
    .o_buzzer_out(o_buzzer_out), .o_irq(o_irq));
`default_nettype wire

// file: tb/tb_hw_monitor_limit_status.sv
// Self-checking bench for the hardware-monitor limit block.
// Assumes the front-end model and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_hw_monitor_limit_status;
    import hwm_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } hwm_row_type;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    hwm_reg_req_type req = '0;
    hwm_reading_type rdg;
    hwm_reading_type cur;
    logic tog;
    logic [7:0] rdata;
    logic evt_n;
    logic buzz;
    logic irq;
    int miscompares = 0;
    int comparisons = 0;
    hwm_row_type rows [26] = '{
        '{8'h10, 1'b0, 8'h00, 8'h00}, '{8'h13, 1'b0, 8'h00, 8'h00},
        '{8'h32, 1'b0, 8'h00, 8'hFF}, '{8'h60, 1'b0, 8'h00, 8'h00},
        '{8'h6C, 1'b0, 8'h00, 8'h40}, '{8'h6D, 1'b0, 8'h00, 8'h04},
        '{8'h82, 1'b0, 8'h00, 8'h64}, '{8'h11, 1'b0, 8'h00, 8'h00},
        '{8'h61, 1'b0, 8'h00, 8'h00}, '{8'h12, 1'b0, 8'h00, 8'h00},
        '{8'h62, 1'b0, 8'h00, 8'h00}, '{8'h2A, 1'b0, 8'h00, 8'hFF},
        '{8'h83, 1'b0, 8'h00, 8'h55}, '{8'h84, 1'b0, 8'h00, 8'h64},
        '{8'h85, 1'b0, 8'h00, 8'h55}, '{8'hF1, 1'b0, 8'h00, 8'h00},
        '{8'hF0, 1'b0, 8'h00, 8'h00},
        '{8'h50, 1'b0, 8'h00, 8'h00}, '{8'h10, 1'b1, 8'hFF, 8'h02},
        '{8'h13, 1'b1, 8'hFF, 8'h02}, '{8'h60, 1'b1, 8'hFF, 8'h66},
        '{8'h32, 1'b1, 8'h80, 8'h80}, '{8'h12, 1'b1, 8'hFF, 8'h00},
        '{8'h6C, 1'b1, 8'h3F, 8'h30}, '{8'h6D, 1'b1, 8'hFF, 8'h0F},
        '{8'h82, 1'b1, 8'h50, 8'h50}};
    always #4 i_clk = ~i_clk;
    hwm_front_end fe (.i_clk(i_clk), .o_reading(rdg), .o_sample_toggle(tog));
    hwm_limit_status dut (.i_clk(i_clk), .i_rst(i_rst), .i_reading(rdg),
        .i_sample_toggle(tog), .i_req(req), .o_rdata(rdata),
        .o_power_mgmt_event_out_n(evt_n), .o_buzzer_out(buzz), .o_irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        req <= '0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        req <= '0;
        #1;
        check(rdata, e);
    endtask : rd_reg
    // Expected event_n, buzzer, irq
    task automatic outs(input logic [2:0] e);
        repeat (2) @(posedge i_clk);
        #1;
        check({5'h00, evt_n, buzz, irq}, {5'h00, e});
    endtask : outs
    function automatic hwm_reading_type mk(input logic [7:0] c, t1, t2);
        return {8'h11, c, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, t1, t2};
    endfunction : mk
    task automatic close_out();
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (6000) @(posedge i_clk);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) wr_reg(rows[i].addr, rows[i].wdata);
            rd_reg(rows[i].addr, rows[i].exp);
        end
        $display("register table test done");
        cur = mk(8'h80, 8'h20, 8'h20);
        fe.send(cur, 0);
        for (int i = 0; i < 7; i++) rd_reg(8'h20 + 8'(i), cur[71 - 8 * i -: 8]);
        rd_reg(8'h72, 8'h20);
        rd_reg(8'h74, 8'h20);
        rd_reg(8'h12, 8'h00);
        rd_reg(8'h11, 8'h00);
        outs(3'b100);
        $display("readings test done");
        fe.send(mk(8'h81, 8'h20, 8'h20), 2);
        rd_reg(8'h12, 8'h02);
        rd_reg(8'h11, 8'h02);
        outs(3'b010);
        wr_reg(8'h10, 8'h00);
        outs(3'b110);
        wr_reg(8'h10, 8'h02);
        wr_reg(8'h11, 8'h00);
        rd_reg(8'h11, 8'h02);
        wr_reg(8'h11, 8'h02);
        outs(3'b110);
        wr_reg(8'h13, 8'h00);
        outs(3'b100);
        fe.send(mk(8'h80, 8'h20, 8'h20), 0);
        rd_reg(8'h11, 8'h02);
        wr_reg(8'h11, 8'h02);
        $display("core voltage test done");
        fe.send(mk(8'h80, 8'h51, 8'h20), 0);
        rd_reg(8'h62, 8'h20);
        rd_reg(8'h61, 8'h20);
        outs(3'b000);
        fe.send(mk(8'h80, 8'h4D, 8'h20), 0);
        rd_reg(8'h62, 8'h20);
        wr_reg(8'h61, 8'h20);
        outs(3'b100);
        fe.send(mk(8'h80, 8'h4C, 8'h20), 0);
        rd_reg(8'h62, 8'h00);
        rd_reg(8'h61, 8'h20);
        wr_reg(8'h61, 8'hFF);
        fe.send(mk(8'h80, 8'h56, 8'h65), 0);
        rd_reg(8'h62, 8'h66);
        rd_reg(8'h61, 8'h66);
        wr_reg(8'h60, 8'h00);
        outs(3'b100);
        wr_reg(8'h60, 8'h04);
        outs(3'b000);
        $display("temperature test done");
        wr_reg(8'hF0, 8'hFF);
        wr_reg(8'h61, 8'hFF);
        fe.send(mk(8'h80, 8'h56, 8'h20), 0);
        rd_reg(8'h61, 8'h44);
        rd_reg(8'hF0, 8'h14);
        outs(3'b000);
        wr_reg(8'hF1, 8'h10);
        outs(3'b001);
        wr_reg(8'hF0, 8'h10);
        outs(3'b000);
        rd_reg(8'hF0, 8'h04);
        $display("interrupt test done");
        wr_reg(8'h83, 8'hA0);
        rd_reg(8'h83, 8'hA0);
        wr_reg(8'h84, 8'hA1);
        rd_reg(8'h84, 8'hA1);
        wr_reg(8'h85, 8'hA2);
        rd_reg(8'h85, 8'hA2);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        outs(3'b100);
        rd_reg(8'h32, 8'hFF);
        rd_reg(8'h85, 8'h55);
        // Late enough to see a false sample taken after reset
        rd_reg(8'h62, 8'h00);
        rd_reg(8'h61, 8'h00);
        $display("reset test done");
        close_out();
    end
endmodule : tb_hw_monitor_limit_status
`default_nettype wire

// file: verilog/hwm_limit_status.sv
// Hardware-monitor limit comparison, change flags, event and buzzer outputs, register file.
// Assumes the front end holds i_reading stable around each toggle of i_sample_toggle.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "hwm_params.svh"

module hwm_limit_status (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Sensing front end
    input wire hwm_pkg::hwm_reading_type i_reading,
    input wire logic i_sample_toggle,
    // Register port
    input wire hwm_pkg::hwm_reg_req_type i_req,
    output logic [7:0] o_rdata,
    // Events
    output logic o_power_mgmt_event_out_n,
    output logic o_buzzer_out,
    output logic o_irq
);
    import hwm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Sample strobe crossing

    logic [`HWM_SYNC_W-1:0] smp_sync_r;
    logic smp_stable_r;
    logic eval_r;
    hwm_reading_type rd_r;
    wire smp_agree = smp_sync_r[1] == smp_sync_r[2];
    wire new_sample = smp_agree && (smp_sync_r[2] != smp_stable_r);

    // Synchroniser runs through reset, so a high pin is never taken for a toggle
    always_ff @(posedge i_clk) begin
        smp_sync_r <= {smp_sync_r[`HWM_SYNC_W-2:0], i_sample_toggle};
        if (i_rst) begin
            // Needs three reset cycles after power-up to settle
            smp_stable_r <= smp_sync_r[1];
            eval_r <= 1'b0;
        end else begin
            if (smp_agree) begin
                smp_stable_r <= smp_sync_r[2];
            end
            eval_r <= new_sample;
        end
    end

    // Readings have no reset value; they are only read after a first sample
    always_ff @(posedge i_clk) begin
        if (new_sample) begin
            rd_r <= i_reading;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    wire wr = i_req.wr;
    wire [7:0] wd = i_req.wdata;
    wire wr_volt_en = wr && (i_req.addr == `HWM_OFF_VOLT_EVT_EN);
    wire wr_volt_chg = wr && (i_req.addr == `HWM_OFF_VOLT_CHG);
    wire wr_volt_buz = wr && (i_req.addr == `HWM_OFF_VOLT_BUZ_EN);
    wire wr_volt_high = wr && (i_req.addr == `HWM_OFF_VOLT_HIGH);
    wire wr_th_en = wr && (i_req.addr == `HWM_OFF_TH_EVT_EN);
    wire wr_th_chg = wr && (i_req.addr == `HWM_OFF_TH_CHG);
    wire wr_hys1 = wr && (i_req.addr == `HWM_OFF_CH1_HYS);
    wire wr_hys2 = wr && (i_req.addr == `HWM_OFF_CH2_HYS);
    wire wr_ovh1 = wr && (i_req.addr == `HWM_OFF_CH1_OVH_LIM);
    wire wr_high1 = wr && (i_req.addr == `HWM_OFF_CH1_HIGH_LIM);
    wire wr_ovh2 = wr && (i_req.addr == `HWM_OFF_CH2_OVH_LIM);
    wire wr_high2 = wr && (i_req.addr == `HWM_OFF_CH2_HIGH_LIM);
    wire wr_irq_sts = wr && (i_req.addr == `HWM_OFF_IRQ_STS);
    wire wr_irq_mask = wr && (i_req.addr == `HWM_OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    logic core_volt_event_enable_r;
    logic core_volt_buzzer_enable_r;
    logic [7:0] core_volt_upper_bound_r;
    logic [`HWM_EV_W-1:0] th_evt_en_r;
    logic [3:0] hys_r [2];
    logic [7:0] ovh_lim_r [2];
    logic [7:0] high_lim_r [2];
    logic [`HWM_EV_W-1:0] irq_mask_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            core_volt_event_enable_r <= 1'b0;
            core_volt_buzzer_enable_r <= 1'b0;
            core_volt_upper_bound_r <= `HWM_RST_VOLT_HIGH;
            th_evt_en_r <= '0;
            hys_r[0] <= `HWM_RST_HYS;
            hys_r[1] <= `HWM_RST_HYS;
            ovh_lim_r[0] <= `HWM_RST_OVH_LIM;
            ovh_lim_r[1] <= `HWM_RST_OVH_LIM;
            high_lim_r[0] <= `HWM_RST_HIGH_LIM;
            high_lim_r[1] <= `HWM_RST_HIGH_LIM;
            irq_mask_r <= '0;
        end else begin
            if (wr_volt_en) begin
                core_volt_event_enable_r <= wd[`HWM_BIT_CORE];
            end
            if (wr_volt_buz) begin
                core_volt_buzzer_enable_r <= wd[`HWM_BIT_CORE];
            end
            if (wr_volt_high) begin
                core_volt_upper_bound_r <= wd;
            end
            if (wr_th_en) begin
                th_evt_en_r[`HWM_EV_CH1_HIGH] <= wd[`HWM_BIT_CH1_HIGH];
                th_evt_en_r[`HWM_EV_CH2_HIGH] <= wd[`HWM_BIT_CH2_HIGH];
                th_evt_en_r[`HWM_EV_CH1_OVH] <= wd[`HWM_BIT_CH1_OVH];
                th_evt_en_r[`HWM_EV_CH2_OVH] <= wd[`HWM_BIT_CH2_OVH];
            end
            if (wr_hys1) begin
                hys_r[0] <= wd[`HWM_CH1_HYS_LSB +: 4];
            end
            if (wr_hys2) begin
                hys_r[1] <= wd[`HWM_CH2_HYS_LSB +: 4];
            end
            if (wr_ovh1) begin
                ovh_lim_r[0] <= wd;
            end
            if (wr_high1) begin
                high_lim_r[0] <= wd;
            end
            if (wr_ovh2) begin
                ovh_lim_r[1] <= wd;
            end
            if (wr_high2) begin
                high_lim_r[1] <= wd;
            end
            if (wr_irq_mask) begin
                irq_mask_r <= wd[`HWM_EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Live comparisons

    logic [`HWM_EV_W-1:0] live_r;
    logic [`HWM_EV_W-1:0] live_nxt;
    wire [7:0] temp_rd [2];
    assign temp_rd[0] = rd_r.thermal_channel_one;
    assign temp_rd[1] = rd_r.thermal_channel_two;

    // Core voltage has no hysteresis: strictly above sets, equal or below clears
    assign live_nxt[`HWM_EV_CORE] = eval_r ?
        (rd_r.core_voltage_input > core_volt_upper_bound_r) : live_r[`HWM_EV_CORE];

    // Signed release point so a limit below the hysteresis never wraps
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_th
            wire signed [9:0] t_s = {2'b00, temp_rd[ch]};
            wire signed [9:0] ovh_rel = {2'b00, ovh_lim_r[ch]} - {6'b000000, hys_r[ch]};
            wire signed [9:0] high_rel = {2'b00, high_lim_r[ch]} - {6'b000000, hys_r[ch]};
            wire ovh_old = live_r[`HWM_EV_CH1_OVH + ch];
            wire high_old = live_r[`HWM_EV_CH1_HIGH + ch];
            wire ovh_new = (temp_rd[ch] > ovh_lim_r[ch]) ? 1'b1 :
                           (t_s < ovh_rel) ? 1'b0 : ovh_old;
            wire high_new = (temp_rd[ch] > high_lim_r[ch]) ? 1'b1 :
                            (t_s < high_rel) ? 1'b0 : high_old;
            assign live_nxt[`HWM_EV_CH1_OVH + ch] = eval_r ? ovh_new : ovh_old;
            assign live_nxt[`HWM_EV_CH1_HIGH + ch] = eval_r ? high_new : high_old;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Change flags and events

    logic [`HWM_EV_W-1:0] chg_r;
    logic [`HWM_EV_W-1:0] irq_sts_r;
    wire [`HWM_EV_W-1:0] edge_ev = live_nxt ^ live_r;
    wire [`HWM_EV_W-1:0] chg_clr;
    assign chg_clr[`HWM_EV_CORE] = wr_volt_chg && wd[`HWM_BIT_CORE];
    assign chg_clr[`HWM_EV_CH1_HIGH] = wr_th_chg && wd[`HWM_BIT_CH1_HIGH];
    assign chg_clr[`HWM_EV_CH2_HIGH] = wr_th_chg && wd[`HWM_BIT_CH2_HIGH];
    assign chg_clr[`HWM_EV_CH1_OVH] = wr_th_chg && wd[`HWM_BIT_CH1_OVH];
    assign chg_clr[`HWM_EV_CH2_OVH] = wr_th_chg && wd[`HWM_BIT_CH2_OVH];
    wire [`HWM_EV_W-1:0] irq_clr = wr_irq_sts ? wd[`HWM_EV_W-1:0] : '0;
    wire [`HWM_EV_W-1:0] chg_nxt = (chg_r & ~chg_clr) | edge_ev;
    wire [`HWM_EV_W-1:0] ev_en = {th_evt_en_r[`HWM_EV_W-1:1], core_volt_event_enable_r};
    wire [`HWM_EV_W-1:0] irq_nxt = (irq_sts_r & ~irq_clr) | edge_ev;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            live_r <= '0;
            chg_r <= '0;
            irq_sts_r <= '0;
            o_power_mgmt_event_out_n <= 1'b1;
            o_buzzer_out <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            live_r <= live_nxt;
            chg_r <= chg_nxt;
            irq_sts_r <= irq_nxt;
            // Held low until the flag or its enable is cleared
            o_power_mgmt_event_out_n <= ~|(chg_nxt & ev_en);
            o_buzzer_out <= live_nxt[`HWM_EV_CORE] & core_volt_buzzer_enable_r;
            o_irq <= |(irq_nxt & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    wire [7:0] a = i_req.addr;
    wire [7:0] pos_core = 8'h01 << `HWM_BIT_CORE;
    wire [7:0] th_chg_b;
    wire [7:0] th_live_b;
    wire [7:0] th_en_b;
    assign th_chg_b = {1'b0, chg_r[`HWM_EV_CH2_OVH], chg_r[`HWM_EV_CH1_OVH], 2'b00,
                       chg_r[`HWM_EV_CH2_HIGH], chg_r[`HWM_EV_CH1_HIGH], 1'b0};
    assign th_live_b = {1'b0, live_r[`HWM_EV_CH2_OVH], live_r[`HWM_EV_CH1_OVH], 2'b00,
                        live_r[`HWM_EV_CH2_HIGH], live_r[`HWM_EV_CH1_HIGH], 1'b0};
    assign th_en_b = {1'b0, th_evt_en_r[`HWM_EV_CH2_OVH], th_evt_en_r[`HWM_EV_CH1_OVH], 2'b00,
                      th_evt_en_r[`HWM_EV_CH2_HIGH], th_evt_en_r[`HWM_EV_CH1_HIGH], 1'b0};
    wire in_ff = (a >= `HWM_OFF_RSVD_FF_LO) && (a <= `HWM_OFF_RSVD_FF_HI);
    wire [7:0] rd_mux =
        (a == `HWM_OFF_VOLT_EVT_EN) ? (core_volt_event_enable_r ? pos_core : 8'h00) :
        (a == `HWM_OFF_VOLT_CHG) ? (chg_r[`HWM_EV_CORE] ? pos_core : 8'h00) :
        (a == `HWM_OFF_VOLT_LIVE) ? (live_r[`HWM_EV_CORE] ? pos_core : 8'h00) :
        (a == `HWM_OFF_VOLT_BUZ_EN) ? (core_volt_buzzer_enable_r ? pos_core : 8'h00) :
        (a == `HWM_OFF_MAIN_RD) ? rd_r.main_supply_rail :
        (a == `HWM_OFF_CORE_RD) ? rd_r.core_voltage_input :
        (a == `HWM_OFF_IN1_RD) ? rd_r.volt_in1 :
        (a == `HWM_OFF_IN2_RD) ? rd_r.volt_in2 :
        (a == `HWM_OFF_IN3_RD) ? rd_r.volt_in3 :
        (a == `HWM_OFF_STBY_RD) ? rd_r.standby_supply_rail :
        (a == `HWM_OFF_BATT_RD) ? rd_r.battery :
        in_ff ? `HWM_RSVD_FF :
        (a == `HWM_OFF_VOLT_HIGH) ? core_volt_upper_bound_r :
        (a == `HWM_OFF_TH_EVT_EN) ? th_en_b :
        (a == `HWM_OFF_TH_CHG) ? th_chg_b :
        (a == `HWM_OFF_TH_LIVE) ? th_live_b :
        (a == `HWM_OFF_CH1_HYS) ? {hys_r[0], 4'h0} :
        (a == `HWM_OFF_CH2_HYS) ? {4'h0, hys_r[1]} :
        (a == `HWM_OFF_TH1_RD) ? rd_r.thermal_channel_one :
        (a == `HWM_OFF_TH2_RD) ? rd_r.thermal_channel_two :
        (a == `HWM_OFF_CH1_OVH_LIM) ? ovh_lim_r[0] :
        (a == `HWM_OFF_CH1_HIGH_LIM) ? high_lim_r[0] :
        (a == `HWM_OFF_CH2_OVH_LIM) ? ovh_lim_r[1] :
        (a == `HWM_OFF_CH2_HIGH_LIM) ? high_lim_r[1] :
        (a == `HWM_OFF_IRQ_STS) ? {3'b000, irq_sts_r} :
        (a == `HWM_OFF_IRQ_MASK) ? {3'b000, irq_mask_r} : 8'h00;

    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_req.rd ? rd_mux : 8'h00;
        end
    end

endmodule : hwm_limit_status
`default_nettype wire

// file: verilog/hwm_params.svh
// Offsets, field positions, reset values and counts for the hardware-monitor limit block.
// Assumes byte-wide registers on an 8-bit register address.
`ifndef HWM_PARAMS_SVH
`define HWM_PARAMS_SVH

// Register offsets
`define HWM_OFF_VOLT_EVT_EN 8'h10
`define HWM_OFF_VOLT_CHG 8'h11
`define HWM_OFF_VOLT_LIVE 8'h12
`define HWM_OFF_VOLT_BUZ_EN 8'h13
`define HWM_OFF_MAIN_RD 8'h20
`define HWM_OFF_CORE_RD 8'h21
`define HWM_OFF_IN1_RD 8'h22
`define HWM_OFF_IN2_RD 8'h23
`define HWM_OFF_IN3_RD 8'h24
`define HWM_OFF_STBY_RD 8'h25
`define HWM_OFF_BATT_RD 8'h26
`define HWM_OFF_RSVD_FF_LO 8'h29
`define HWM_OFF_RSVD_FF_HI 8'h2F
`define HWM_OFF_VOLT_HIGH 8'h32
`define HWM_OFF_TH_EVT_EN 8'h60
`define HWM_OFF_TH_CHG 8'h61
`define HWM_OFF_TH_LIVE 8'h62
`define HWM_OFF_CH1_HYS 8'h6C
`define HWM_OFF_CH2_HYS 8'h6D
`define HWM_OFF_TH1_RD 8'h72
`define HWM_OFF_TH2_RD 8'h74
`define HWM_OFF_CH1_OVH_LIM 8'h82
`define HWM_OFF_CH1_HIGH_LIM 8'h83
`define HWM_OFF_CH2_OVH_LIM 8'h84
`define HWM_OFF_CH2_HIGH_LIM 8'h85
`define HWM_OFF_IRQ_STS 8'hF0
`define HWM_OFF_IRQ_MASK 8'hF1

// Field positions
`define HWM_BIT_CORE 1
`define HWM_BIT_CH2_OVH 6
`define HWM_BIT_CH1_OVH 5
`define HWM_BIT_CH2_HIGH 2
`define HWM_BIT_CH1_HIGH 1
`define HWM_CH1_HYS_LSB 4
`define HWM_CH2_HYS_LSB 0

// Event vector indices and width
`define HWM_EV_CORE 0
`define HWM_EV_CH1_HIGH 1
`define HWM_EV_CH2_HIGH 2
`define HWM_EV_CH1_OVH 3
`define HWM_EV_CH2_OVH 4
`define HWM_EV_W 5

// Reset values and the reserved-range read value
`define HWM_RST_VOLT_HIGH 8'hFF
`define HWM_RST_HYS 4'h4
`define HWM_RST_OVH_LIM 8'h64
`define HWM_RST_HIGH_LIM 8'h55
`define HWM_RSVD_FF 8'hFF

// Synchroniser depth for the sample toggle
`define HWM_SYNC_W 3

`endif

// file: verilog/hwm_pkg.sv
// Types shared by the hardware-monitor limit block and its bench.
// Assumes the front end delivers 8-bit readings.
`default_nettype none
package hwm_pkg;

    // One full set of readings from the sensing front end
    typedef struct packed {
        logic [7:0] main_supply_rail;
        logic [7:0] core_voltage_input;
        logic [7:0] volt_in1;
        logic [7:0] volt_in2;
        logic [7:0] volt_in3;
        logic [7:0] standby_supply_rail;
        logic [7:0] battery;
        logic [7:0] thermal_channel_one;
        logic [7:0] thermal_channel_two;
    } hwm_reading_type;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hwm_reg_req_type;

endpackage : hwm_pkg
`default_nettype wire
